// ==== design/swm_master_timing.sv ====
// Single-wire bus master timing engine: reset, presence, bit slots, strong pullup
`timescale 1ns/1ps
`default_nettype none
module swm_master_timing #(
   parameter int unsigned TICK_STD_CYCLES = swm_pkg::TICK_STD_CYCLES,
   parameter int unsigned TICK_OD_CYCLES = swm_pkg::TICK_OD_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire swm_pkg::swm_speed_type speed_mode,
   input wire logic line_hold_low_mode,
   input wire logic pullup_hold_mode,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire swm_pkg::swm_cmd_type cmd,
   output logic res_valid,
   input wire logic res_ready,
   output swm_pkg::swm_result_type res_data,
   input wire logic bus_line_in,
   output logic bus_line_out,
   output logic bus_line_oe,
   output logic strong_pullup_enable_n
);

   // ****************************************
   // Declarations
   // ****************************************
   typedef enum logic [2:0] {ST_IDLE, ST_LEAD, ST_RST_LOW, ST_RST_HIGH, ST_SLOT_LOW, ST_SLOT_REST,
                             ST_PUSH} swm_state_type;
   typedef enum logic [2:0] {SP_OFF, SP_DELAY, SP_WAIT_HIGH, SP_ON, SP_HOLD} swm_spu_state_type;

   localparam int unsigned TW = swm_pkg::TIMER_W;

   swm_state_type state;
   swm_spu_state_type spu_state;
   swm_pkg::swm_cmd_type cur_cmd;
   swm_pkg::swm_speed_type cur_speed;
   logic [swm_pkg::TICK_CNT_W-1:0] tick_cnt;
   logic tick;
   logic [TW-1:0] elapsed;
   logic [TW-1:0] now;
   logic line_meta;
   logic line_sync;
   logic presence;
   logic read_val;
   logic drive_low;
   logic accept;
   logic [TW-1:0] spu_timer;
   logic [TW-1:0] spu_delay;
   logic [TW-1:0] spu_on_len;
   logic spu_chain;
   logic spu_hold_after;
   logic spu_start;
   logic [TW-1:0] start_delay;
   logic [TW-1:0] start_on;
   logic start_chain;
   logic start_hold;
   logic buf_in_ready;
   swm_pkg::swm_result_type push_data;

   // Tick count reached: count is zero based, so one is added and the limit ends after exactly limit ticks
   function automatic logic reached(input logic [TW-1:0] count, input logic [TW-1:0] limit);
      return ({1'b0, count} + (TW+1)'(1)) >= {1'b0, limit};
   endfunction

   // ****************************************
   // Line input synchroniser
   // ****************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         line_meta <= 1'b1;
         line_sync <= 1'b1;
      end else begin
         line_meta <= bus_line_in;
         line_sync <= line_meta;
      end
   end

   // ****************************************
   // Tick generator
   // ****************************************
   // Integer cycle counts only; a fractional tick would stretch every maximum
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt <= '0;
      end else if (accept || tick) begin
         tick_cnt <= '0;
      end else begin
         tick_cnt <= tick_cnt + 1'b1;
      end
   end

   assign tick = (cur_speed == swm_pkg::SWM_SPEED_OD) ?
                 (tick_cnt == swm_pkg::TICK_CNT_W'(TICK_OD_CYCLES - 1)) :
                 (tick_cnt == swm_pkg::TICK_CNT_W'(TICK_STD_CYCLES - 1));

   // ****************************************
   // Command acceptance and speed latch
   // ****************************************
   assign cmd_ready = (state == ST_IDLE);
   assign accept = cmd_valid && cmd_ready;
   assign now = TW'(elapsed + 1'b1);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cur_cmd <= '0;
         cur_speed <= swm_pkg::SWM_SPEED_STD;
      end else if (accept) begin
         cur_cmd <= cmd;
         cur_speed <= speed_mode;
      end
   end

   // ****************************************
   // Main sequencer
   // ****************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         elapsed <= '0;
      end else begin
         unique case (state)
            ST_IDLE: begin
               elapsed <= '0;
               if (accept) begin
                  state <= ST_LEAD;
               end
            end
            ST_LEAD: begin
               if (tick) begin
                  elapsed <= now;
                  if (cur_cmd.kind == swm_pkg::SWM_CMD_RESET) begin
                     if (reached(elapsed, swm_pkg::swm_ticks(cur_speed, swm_pkg::OFF1_STD_NS,
                                 swm_pkg::OFF1_OD_NS, swm_pkg::OFF1_STD_NS))) begin
                        state <= ST_RST_LOW;
                        elapsed <= '0;
                     end
                  end else if (cur_cmd.first_bit) begin
                     if (reached(elapsed, swm_pkg::swm_ticks(cur_speed, swm_pkg::OFF_FIRST_NS,
                                 swm_pkg::OFF_FIRST_NS, swm_pkg::OFF_FIRST_NS))) begin
                        state <= ST_SLOT_LOW;
                        elapsed <= '0;
                     end
                  end else if (reached(elapsed, swm_pkg::swm_ticks(cur_speed, swm_pkg::OFF2_STD_NS,
                               swm_pkg::OFF2_OD_NS, swm_pkg::OFF2_STD_NS))) begin
                     state <= ST_SLOT_LOW;
                     elapsed <= '0;
                  end
               end
            end
            ST_RST_LOW: begin
               if (tick) begin
                  elapsed <= now;
                  if (reached(elapsed, swm_pkg::swm_ticks(cur_speed, swm_pkg::RST_LOW_STD_NS,
                              swm_pkg::RST_LOW_OD_NS, swm_pkg::RST_LOW_STD_NS))) begin
                     state <= ST_RST_HIGH;
                     elapsed <= '0;
                  end
               end
            end
            ST_RST_HIGH: begin
               if (tick) begin
                  elapsed <= now;
                  if (reached(elapsed, swm_pkg::swm_ticks(cur_speed, swm_pkg::RST_HIGH_STD_NS,
                              swm_pkg::RST_HIGH_OD_NS, swm_pkg::RST_HIGH_STD_NS))) begin
                     state <= ST_PUSH;
                  end
               end
            end
            ST_SLOT_LOW: begin
               if (tick) begin
                  elapsed <= now;
                  if ((cur_cmd.kind == swm_pkg::SWM_CMD_WRITE) && !cur_cmd.bit_value) begin
                     if (reached(elapsed, swm_pkg::swm_ticks(cur_speed, swm_pkg::LOW0_STD_NS,
                                 swm_pkg::LOW0_OD_NS, swm_pkg::LOW0_STD_NS))) begin
                        state <= ST_SLOT_REST;
                     end
                  end else if (reached(elapsed, swm_pkg::swm_ticks(cur_speed, swm_pkg::LOW1_STD_NS,
                               swm_pkg::LOW1_OD_NS, swm_pkg::LOW1_LONG_NS))) begin
                     state <= ST_SLOT_REST;
                  end
               end
            end
            ST_SLOT_REST: begin
               if (tick) begin
                  elapsed <= now;
                  if (reached(elapsed, swm_pkg::swm_ticks(cur_speed, swm_pkg::SLOT_STD_NS,
                              swm_pkg::SLOT_OD_NS, swm_pkg::SLOT_STD_NS))) begin
                     state <= (cur_cmd.kind == swm_pkg::SWM_CMD_READ) ? ST_PUSH : ST_IDLE;
                  end
               end
            end
            ST_PUSH: begin
               // A full buffer stalls here, so no result is dropped
               if (buf_in_ready) begin
                  state <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // ****************************************
   // Line sampling: presence and read data
   // ****************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         presence <= 1'b0;
         read_val <= 1'b0;
      end else if (accept) begin
         presence <= 1'b0;
         read_val <= 1'b0;
      end else if (tick && (state == ST_RST_HIGH) && !presence && !line_sync) begin
         if ((now >= swm_pkg::swm_ticks(cur_speed, swm_pkg::PDS_STD_NS, swm_pkg::PDS_OD_NS,
              swm_pkg::PDS_LONG_NS)) &&
             (now <= swm_pkg::swm_ticks(cur_speed, swm_pkg::ABSENT_STD_NS, swm_pkg::ABSENT_OD_NS,
              swm_pkg::ABSENT_STD_NS))) begin
            presence <= 1'b1;
         end
      end else if (tick && (state == ST_SLOT_REST) && (now == swm_pkg::swm_ticks(cur_speed,
                   swm_pkg::RDV_STD_NS, swm_pkg::RDV_OD_NS, swm_pkg::RDV_LONG_NS))) begin
         read_val <= line_sync;
      end
   end

   // ****************************************
   // Line drive
   // ****************************************
   always_comb begin
      drive_low = (state == ST_RST_LOW) || (state == ST_SLOT_LOW);
      // Hold mode pulls low once 15 us after release have passed, standard speed only
      if ((state == ST_RST_HIGH) && line_hold_low_mode && (cur_speed == swm_pkg::SWM_SPEED_STD) &&
          (elapsed >= swm_pkg::swm_ticks(cur_speed, swm_pkg::HOLD_LOW_NS, swm_pkg::HOLD_LOW_NS,
           swm_pkg::HOLD_LOW_NS))) begin
         drive_low = 1'b1;
      end
   end

   assign bus_line_out = 1'b0;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_line_oe <= 1'b0;
      end else begin
         bus_line_oe <= drive_low;
      end
   end

   // ****************************************
   // Strong pullup triggers
   // ****************************************
   always_comb begin
      spu_start = 1'b0;
      start_delay = swm_pkg::swm_ticks(cur_speed, swm_pkg::DLY3_STD_NS, swm_pkg::DLY3_OD_NS,
                                       swm_pkg::DLY3_STD_NS);
      start_on = swm_pkg::swm_ticks(cur_speed, swm_pkg::ON3_STD_NS, swm_pkg::ON3_OD_NS,
                                    swm_pkg::ON3_STD_NS);
      start_chain = 1'b0;
      start_hold = cur_cmd.last_bit && pullup_hold_mode;
      if (tick && (state == ST_RST_HIGH) && !presence && !line_sync &&
          (now >= swm_pkg::swm_ticks(cur_speed, swm_pkg::PDS_STD_NS, swm_pkg::PDS_OD_NS,
           swm_pkg::PDS_LONG_NS)) &&
          (now <= swm_pkg::swm_ticks(cur_speed, swm_pkg::ABSENT_STD_NS, swm_pkg::ABSENT_OD_NS,
           swm_pkg::ABSENT_STD_NS))) begin
         spu_start = 1'b1;
         start_delay = swm_pkg::swm_ticks(cur_speed, swm_pkg::DLY1_STD_NS, swm_pkg::DLY1_OD_NS,
                                          swm_pkg::DLY1_STD_NS);
         start_on = swm_pkg::swm_ticks(cur_speed, swm_pkg::ON1_STD_NS, swm_pkg::ON1_OD_NS,
                                       swm_pkg::ON1_STD_NS);
         start_chain = 1'b1;
         start_hold = 1'b0;
      end else if ((state == ST_SLOT_LOW) && (bus_line_oe != drive_low) && !drive_low) begin
         spu_start = 1'b0;
      end else if (tick && (state == ST_SLOT_LOW) && !drive_low) begin
         spu_start = 1'b0;
      end else if ((state == ST_SLOT_REST) && bus_line_oe) begin
         // First cycle after the low phase ends
         spu_start = 1'b1;
         if ((cur_cmd.kind == swm_pkg::SWM_CMD_WRITE) && !cur_cmd.bit_value) begin
            start_on = swm_pkg::swm_ticks(cur_speed, swm_pkg::ON4_STD_NS, swm_pkg::ON4_OD_NS,
                                          swm_pkg::ON4_STD_NS);
         end
      end
   end

   // ****************************************
   // Strong pullup sequencer
   // ****************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         spu_state <= SP_OFF;
         spu_timer <= '0;
         spu_delay <= '0;
         spu_on_len <= '0;
         spu_chain <= 1'b0;
         spu_hold_after <= 1'b0;
      end else if (accept) begin
         spu_state <= SP_OFF;
         spu_timer <= '0;
         spu_chain <= 1'b0;
         spu_hold_after <= 1'b0;
      end else if (spu_start) begin
         spu_state <= SP_DELAY;
         spu_timer <= '0;
         spu_delay <= start_delay;
         spu_on_len <= start_on;
         spu_chain <= start_chain;
         spu_hold_after <= start_hold;
      end else if (tick) begin
         unique case (spu_state)
            SP_OFF, SP_HOLD: begin
               spu_timer <= '0;
            end
            SP_DELAY: begin
               spu_timer <= TW'(spu_timer + 1'b1);
               if (reached(spu_timer, spu_delay)) begin
                  spu_state <= SP_WAIT_HIGH;
                  spu_timer <= '0;
               end
            end
            SP_WAIT_HIGH: begin
               // Line checked once a tick; a low line keeps the pullup off
               if (line_sync) begin
                  spu_state <= SP_ON;
               end
            end
            SP_ON: begin
               spu_timer <= TW'(spu_timer + 1'b1);
               if (reached(spu_timer, spu_on_len)) begin
                  spu_timer <= '0;
                  if (spu_chain) begin
                     spu_state <= SP_DELAY;
                     spu_chain <= 1'b0;
                     spu_delay <= swm_pkg::swm_ticks(cur_speed,
                        swm_pkg::DLY2_STD_NS - swm_pkg::DLY1_STD_NS - swm_pkg::ON1_STD_NS,
                        swm_pkg::DLY2_OD_NS - swm_pkg::DLY1_OD_NS - swm_pkg::ON1_OD_NS,
                        swm_pkg::DLY2_STD_NS - swm_pkg::DLY1_STD_NS - swm_pkg::ON1_STD_NS);
                     spu_on_len <= swm_pkg::swm_ticks(cur_speed, swm_pkg::ON2_STD_NS, swm_pkg::ON2_OD_NS,
                                                      swm_pkg::ON2_STD_NS);
                  end else if (spu_hold_after) begin
                     spu_state <= SP_HOLD;
                  end else begin
                     spu_state <= SP_OFF;
                  end
               end
            end
            default: begin
               spu_state <= SP_OFF;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         strong_pullup_enable_n <= 1'b1;
      end else begin
         strong_pullup_enable_n <= !((spu_state == SP_ON) || (spu_state == SP_HOLD));
      end
   end

   // ****************************************
   // Result buffer
   // ****************************************
   assign push_data.is_presence = (cur_cmd.kind == swm_pkg::SWM_CMD_RESET);
   assign push_data.value = push_data.is_presence ? presence : read_val;

   swm_pair_buffer #(
      .WIDTH(swm_pkg::RESULT_W),
      .DEPTH(swm_pkg::BUF_DEPTH)
   ) u_result_buffer (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(state == ST_PUSH),
      .in_ready(buf_in_ready),
      .in_data(push_data),
      .out_valid(res_valid),
      .out_ready(res_ready),
      .out_data(res_data)
   );
endmodule
`default_nettype wire

// ==== design/swm_pair_buffer.sv ====
// Two-entry result buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module swm_pair_buffer #(
   parameter int unsigned WIDTH = 2,
   parameter int unsigned DEPTH = 2
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;

   function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
      return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
   endfunction

   assign in_ready = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= next_ptr(wr_ptr);
         end
         if (pop) begin
            rd_ptr <= next_ptr(rd_ptr);
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ==== design/swm_pkg.sv ====
// Constants, types and timing helpers of the single-wire master timing engine
package swm_pkg;

   // ****************************************
   // Clock and state-machine tick
   // ****************************************
   localparam int unsigned CLK_PERIOD_NS = 5;
   localparam int unsigned TICK_STD_NS = 1000;
   localparam int unsigned TICK_OD_NS = 50;
   localparam int unsigned TICK_STD_CYCLES = TICK_STD_NS / CLK_PERIOD_NS;
   localparam int unsigned TICK_OD_CYCLES = TICK_OD_NS / CLK_PERIOD_NS;
   localparam int unsigned TICK_CNT_W = 16;
   localparam int unsigned TIMER_W = 12;

   // ****************************************
   // Line timing in ns: standard, overdrive, long
   // ****************************************
   localparam int unsigned RST_LOW_STD_NS = 560000;
   localparam int unsigned RST_LOW_OD_NS = 56000;
   localparam int unsigned RST_HIGH_STD_NS = 570000;
   localparam int unsigned RST_HIGH_OD_NS = 66000;
   localparam int unsigned PDS_STD_NS = 28000;
   localparam int unsigned PDS_OD_NS = 3000;
   localparam int unsigned PDS_LONG_NS = 34000;
   localparam int unsigned ABSENT_STD_NS = 68000;
   localparam int unsigned ABSENT_OD_NS = 7200;
   localparam int unsigned SLOT_STD_NS = 77000;
   localparam int unsigned SLOT_OD_NS = 13500;
   localparam int unsigned LOW1_STD_NS = 5000;
   localparam int unsigned LOW1_OD_NS = 900;
   localparam int unsigned LOW1_LONG_NS = 8000;
   localparam int unsigned LOW0_STD_NS = 70000;
   localparam int unsigned LOW0_OD_NS = 9000;
   localparam int unsigned RDV_STD_NS = 13000;
   localparam int unsigned RDV_OD_NS = 1800;
   localparam int unsigned RDV_LONG_NS = 22000;
   localparam int unsigned HOLD_LOW_NS = 15000;

   // ****************************************
   // Strong pullup timing in ns: standard, overdrive
   // ****************************************
   localparam int unsigned ON1_STD_NS = 7000;
   localparam int unsigned ON1_OD_NS = 900;
   localparam int unsigned ON2_STD_NS = 9000;
   localparam int unsigned ON2_OD_NS = 9000;
   localparam int unsigned ON3_STD_NS = 57000;
   localparam int unsigned ON3_OD_NS = 8000;
   localparam int unsigned ON4_STD_NS = 7000;
   localparam int unsigned ON4_OD_NS = 900;
   localparam int unsigned DLY1_STD_NS = 1000;
   localparam int unsigned DLY1_OD_NS = 900;
   localparam int unsigned DLY2_STD_NS = 450000;
   localparam int unsigned DLY2_OD_NS = 35000;
   localparam int unsigned DLY3_STD_NS = 1000;
   localparam int unsigned DLY3_OD_NS = 900;
   localparam int unsigned OFF1_STD_NS = 2000;
   localparam int unsigned OFF1_OD_NS = 1800;
   localparam int unsigned OFF2_STD_NS = 1000;
   localparam int unsigned OFF2_OD_NS = 900;
   localparam int unsigned OFF_FIRST_NS = 4000;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {SWM_SPEED_STD, SWM_SPEED_OD, SWM_SPEED_LONG} swm_speed_type;
   typedef enum logic [1:0] {SWM_CMD_RESET, SWM_CMD_WRITE, SWM_CMD_READ} swm_cmd_kind_type;

   typedef struct packed {
      swm_cmd_kind_type kind;
      logic bit_value;
      logic first_bit;
      logic last_bit;
   } swm_cmd_type;

   typedef struct packed {
      logic is_presence;
      logic value;
   } swm_result_type;

   localparam int unsigned RESULT_W = $bits(swm_result_type);
   localparam int unsigned BUF_DEPTH = 2;

   // Tick count for a time per speed; long falls back to standard tick
   function automatic logic [TIMER_W-1:0] swm_ticks(input swm_speed_type speed, input int unsigned std_ns,
                                                    input int unsigned od_ns, input int unsigned long_ns);
      int unsigned t;
      t = std_ns / TICK_STD_NS;
      if (speed == SWM_SPEED_OD) begin
         t = od_ns / TICK_OD_NS;
      end else if (speed == SWM_SPEED_LONG) begin
         t = long_ns / TICK_STD_NS;
      end
      return TIMER_W'(t);
   endfunction

endpackage

// ==== tb/swm_master_timing_checker.sv ====
// Port assertions of the single-wire master timing engine
`timescale 1ns/1ps
`default_nettype none
module swm_master_timing_checker #(
   parameter int unsigned TICK_STD_CYCLES = swm_pkg::TICK_STD_CYCLES,
   parameter int unsigned TICK_OD_CYCLES = swm_pkg::TICK_OD_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire swm_pkg::swm_speed_type speed_mode,
   input wire logic line_hold_low_mode,
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire swm_pkg::swm_cmd_type cmd,
   input wire logic res_valid,
   input wire logic res_ready,
   input wire swm_pkg::swm_result_type res_data,
   input wire logic bus_line_oe,
   input wire logic strong_pullup_enable_n
);
   swm_pkg::swm_cmd_type lc;
   logic od, lng;
   int unsigned lw, ex;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lw <= 0;
      end else begin
         lw <= bus_line_oe ? lw + 1 : 0;
         if (cmd_valid && cmd_ready) begin
            lc <= cmd;
            od <= speed_mode == swm_pkg::SWM_SPEED_OD;
            lng <= speed_mode == swm_pkg::SWM_SPEED_LONG;
         end
      end
   end
   // Expected low time in cycles; hold-low phases are excluded below
   assign ex = (lc.kind == swm_pkg::SWM_CMD_RESET ? (od ? 1120 : 560) : lc.kind == swm_pkg::SWM_CMD_WRITE &&
      !lc.bit_value ? (od ? 180 : 70) : od ? 18 : lng ? 8 : 5) * (od ? TICK_OD_CYCLES : TICK_STD_CYCLES);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   chk_ready_drop: assert property (cmd_valid && cmd_ready |=> !cmd_ready)
      else $error("ready high after accept");
   chk_accept_pull_off: assert property (cmd_valid && cmd_ready |-> ##2 strong_pullup_enable_n)
      else $error("pullup on after accept");
   chk_low_pull_off: assert property (bus_line_oe |-> strong_pullup_enable_n)
      else $error("pullup on while low");
   chk_low_width: assert property ($fell(bus_line_oe) && !line_hold_low_mode |-> lw == ex)
      else $error("low time wrong");
   chk_idle_released: assert property (cmd_ready && !line_hold_low_mode |-> !bus_line_oe)
      else $error("line driven while idle");
   chk_lead_pull_off: assert property ($rose(bus_line_oe) && !line_hold_low_mode |-> $past(strong_pullup_enable_n, 3))
      else $error("no turn-off lead");
   chk_busy_low: assert property ($rose(bus_line_oe) |-> !cmd_ready)
      else $error("idle during slot");
   chk_result_held: assert property (res_valid && !res_ready |=> res_valid && $stable(res_data))
      else $error("result lost in stall");
endmodule
bind swm_master_timing swm_master_timing_checker #(.TICK_STD_CYCLES(TICK_STD_CYCLES), .TICK_OD_CYCLES(TICK_OD_CYCLES))
   i_swm_master_timing_checker (.*);
`default_nettype wire

// ==== tb/swm_master_timing_tb.sv ====
// Bench of the single-wire master timing engine
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin failures++; $display("Error %0t mismatch", $time); end end
`define WT(c) begin n = 0; while ((c) !== 1'b1 && n < 9000) begin @(posedge clk); #1; n++; end if ((c) !== 1'b1) begin failures++; end_sim(); end end
module swm_master_timing_tb;
   localparam int TS = 4;
   localparam int TO = 2;
   logic clk = 0, rst_n = 0, hold = 0, pu_hold = 0, cmd_valid = 0, res_ready = 0, present = 1, rd_bit = 1, od = 0;
   logic cmd_ready, res_valid, line_out, oe, pu_n, pull_low, got_bit;
   swm_pkg::swm_speed_type speed = swm_pkg::SWM_SPEED_STD;
   swm_pkg::swm_cmd_type cmd = '0;
   swm_pkg::swm_result_type res;
   wire logic bus_line = !(oe || pull_low);
   int failures = 0, compares = 0, n, lo;
   always #2.5 clk = !clk;
   swm_master_timing #(.TICK_STD_CYCLES(TS), .TICK_OD_CYCLES(TO)) i_swm_master_timing (.clk(clk), .rst_n(rst_n),
      .speed_mode(speed), .line_hold_low_mode(hold), .pullup_hold_mode(pu_hold), .cmd_valid(cmd_valid), .cmd(cmd),
      .cmd_ready(cmd_ready), .res_valid(res_valid), .res_ready(res_ready), .res_data(res), .bus_line_in(bus_line),
      .bus_line_out(line_out), .bus_line_oe(oe), .strong_pullup_enable_n(pu_n));
   swm_slave_model i_swm_slave_model (.bus_line(bus_line), .present(present), .rd_bit(rd_bit), .od(od),
      .pull_low(pull_low), .got_bit(got_bit));
   task automatic end_sim();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic send(input swm_pkg::swm_cmd_kind_type k, input logic b, input logic f,
                       input swm_pkg::swm_speed_type s);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd <= '{k, b, f, 1'b1};
      speed <= s;
      od <= s == swm_pkg::SWM_SPEED_OD;
      #1;
      `WT(cmd_ready)
      @(posedge clk);
      cmd_valid <= 1'b0;
      lo = od ? (k == swm_pkg::SWM_CMD_RESET ? 36 : f ? 80 : 18) * TO : (k == swm_pkg::SWM_CMD_RESET ? 2 : f ? 4 : 1) * TS;
      `WT(oe)
      `CHK(n >= lo && n <= lo + 2, 1'b1)
      `WT(cmd_ready)
   endtask
   task automatic pop(input logic p, input logic v);
      // Step off the popping edge so the buffer has moved on
      #1;
      `WT(res_valid)
      `CHK(res, {p, v})
      @(posedge clk);
      res_ready <= 1'b1;
      @(posedge clk);
      res_ready <= 1'b0;
   endtask
   // Hold-low mode at standard speed makes the master see its own low as presence
   task automatic sc_reset(input swm_pkg::swm_speed_type s, input logic p, input logic h, input logic e);
      present = p;
      @(posedge clk);
      hold <= h;
      send(swm_pkg::SWM_CMD_RESET, 1'b0, 1'b0, s);
      pop(1'b1, e);
      hold <= 1'b0;
   endtask
   task automatic sc_write(input swm_pkg::swm_speed_type s, input logic b);
      send(swm_pkg::SWM_CMD_WRITE, b, 1'b0, s);
      `CHK(got_bit, b)
      `CHK(line_out, 1'b0)
   endtask
   // Two results wait in the buffer while the consumer stalls
   task automatic sc_read_pair();
      rd_bit = 1'b0;
      send(swm_pkg::SWM_CMD_READ, 1'b0, 1'b1, swm_pkg::SWM_SPEED_STD);
      rd_bit = 1'b1;
      send(swm_pkg::SWM_CMD_READ, 1'b0, 1'b0, swm_pkg::SWM_SPEED_OD);
      pop(1'b0, 1'b0);
      pop(1'b0, 1'b1);
   endtask
   task automatic sc_pullup(input logic b, input logic h, input logic late);
      @(posedge clk);
      pu_hold <= h;
      send(swm_pkg::SWM_CMD_WRITE, b, 1'b0, swm_pkg::SWM_SPEED_STD);
      // Pullup still on just after the slot ends: held after the write one, write-zero recovery window after the write zero
      #(TS);
      `CHK(pu_n, 1'b0)
      #(380 * TS);
      `CHK(pu_n, late)
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      sc_reset(swm_pkg::SWM_SPEED_STD, 1'b1, 1'b0, 1'b1);
      sc_reset(swm_pkg::SWM_SPEED_OD, 1'b1, 1'b0, 1'b1);
      sc_reset(swm_pkg::SWM_SPEED_LONG, 1'b0, 1'b0, 1'b0);
      sc_reset(swm_pkg::SWM_SPEED_STD, 1'b0, 1'b1, 1'b1);
      sc_write(swm_pkg::SWM_SPEED_STD, 1'b0);
      sc_write(swm_pkg::SWM_SPEED_OD, 1'b1);
      sc_write(swm_pkg::SWM_SPEED_LONG, 1'b1);
      sc_read_pair();
      sc_pullup(1'b1, 1'b1, 1'b0);
      sc_pullup(1'b0, 1'b0, 1'b1);
      end_sim();
   end
endmodule
`default_nettype wire

// ==== tb/swm_slave_model.sv ====
// Behavioural slave on the open-drain line, times in scaled microseconds
`timescale 1ns/1ps
`default_nettype none
module swm_slave_model (
   input wire logic bus_line,
   input wire logic present,
   input wire logic rd_bit,
   input wire logic od,
   output logic pull_low,
   output logic got_bit
);
   realtime t0, u;
   initial {pull_low, got_bit} = 2'b00;
   always begin
      @(negedge bus_line);
      if (!pull_low) begin
         t0 = $realtime;
         u = od ? 200.0 : 20.0;
         pull_low = !rd_bit;
         #((od ? 4 : 30) * u);
         got_bit = bus_line;
         pull_low = 1'b0;
         wait (bus_line);
         // Long low means reset; slot lows never reach this
         if ($realtime - t0 > (od ? 30 : 300) * u && present) begin
            #((od ? 4 : 20) * u);
            pull_low = 1'b1;
            #((od ? 16 : 100) * u);
            pull_low = 1'b0;
         end
      end
   end
endmodule
`default_nettype wire
